// ==== src/efme_pkg.sv ====
// Constants, state types and the CRC step shared by the framing engine.
// Assumes one core clock; byte-wide PCS side with one control flag per byte.
//
// Functional notes
// - Fields in order, bytes sent LSB first
// - Prepend seven 0x55 preamble bytes on transmit
// - Start delimiter directly after the preamble
// - Receive strips preamble and delimiter
// - First octet bit0 marks multicast; all-ones broadcast
// - Destination then source address kept in data
// - Length/type 1536 or more is a type
// - Recognise VLAN 8100 and PAUSE 8808
// - Transmit forwards length/type unchanged
// - Receive uses length to strip pad
// - Length check flags data size mismatch
// - Type value passed on, field kept
// - Data field 0 to 1500 or jumbo
// - Pad frames to 64 bytes with FCS
// - Padding implies FCS; config selects in-band FCS
// - Receive withholds pad unless FCS passed
// - CRC-32 over addresses, type, data, pad
// - CRC highest-order term sent first
// - Check every FCS; config passes or drops it
// - At least 96 bit times between frames; with CFG_DIC set the code lets a gap fall to 9 bytes
// - Gap timer, then start on 4-byte boundary
// - Deficit idle count keeps mean gap twelve
////////////////////////////////////////////////////////////////////////////////
package efme_pkg;
    // Register byte offsets
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RX_FRAMES = 4'h8;
    localparam logic [3:0] REG_RX_BAD = 4'hC;
    // Config bit positions and reset value
    localparam int CFG_TX_INBAND = 0;
    localparam int CFG_RX_PASS = 1;
    localparam int CFG_LEN_CHK = 2;
    localparam int CFG_DIC = 3;
    localparam logic [3:0] CFG_RESET = 4'h0;
    // Line codes
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [7:0] IDLE_CODE = 8'h07;
    localparam logic [7:0] TERM_CODE = 8'hFD;
    localparam logic [7:0] ERR_CODE = 8'hFE;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    localparam logic [7:0] ONES_BYTE = 8'hFF;
    // Counts
    localparam logic [2:0] PRE_LEN = 3'h7;
    localparam int IFG_BITS = 96;
    localparam logic [3:0] IFG_BYTES = 4'(IFG_BITS / 8);
    localparam logic [3:0] GAP_SAT = 4'hF;
    localparam logic [1:0] DIC_MAX = 2'h3;
    localparam logic [2:0] FCS_LAST = 3'h3;
    localparam logic [15:0] MIN_FRAME = 16'h003C;
    localparam logic [15:0] MIN_DATA = 16'h002E;
    localparam logic [15:0] TYPE_MIN = 16'h0600;
    localparam logic [15:0] LT_VLAN = 16'h8100;
    localparam logic [15:0] LT_PAUSE = 16'h8808;
    localparam logic [15:0] HDR_LEN = 16'h000E;
    localparam logic [15:0] VLAN_HDR = 16'h0012;
    localparam logic [15:0] FCS_LEN = 16'h0004;
    localparam logic [15:0] ADDR_LEN = 16'h0006;
    localparam logic [15:0] LT_POS = 16'h000C;
    localparam logic [15:0] ILT_POS = 16'h0010;
    // Reflected CRC-32
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

    typedef enum logic [2:0] {TX_GAP, TX_PRE, TX_SFD, TX_DATA, TX_PAD, TX_FCS, TX_TERM} efme_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA} efme_rx_st_t;

    // One byte into the CRC, LSB first
    function automatic logic [31:0] efme_crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// ==== src/efme_top.sv ====
// Framing engine: transmit framer, receive deframer, Avalon-MM registers.
// Assumes the PCS and the client run on clk_sys; no stream back-pressure on receive.
////////////////////////////////////////////////////////////////////////////////
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
module efme_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Client transmit bytes
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_valid,
    input wire logic tx_in_last,
    output logic tx_in_ready,
    // PCS transmit
    output logic [7:0] pcs_txd,
    output logic pcs_txc,
    // PCS receive
    input wire logic [7:0] pcs_rxd,
    input wire logic pcs_rxc,
    // Client receive bytes
    output logic [7:0] rx_out_data,
    output logic rx_out_valid,
    output logic rx_out_last,
    output logic rx_out_err
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [3:0] cfg;
        efme_pkg::efme_tx_st_t tx_st;
        logic [7:0] txd;
        logic txc;
        logic [1:0] lane;
        logic [3:0] gap;
        logic [1:0] dic;
        logic [2:0] pcnt;
        logic [15:0] tcnt;
        logic [31:0] tcrc;
        logic [31:0] fcs;
        efme_pkg::efme_rx_st_t rx_st;
        logic [15:0] rcnt;
        logic [15:0] oidx;
        logic [31:0] rcrc;
        logic [31:0] sh;
        logic [7:0] pend;
        logic pv;
        logic [15:0] lt;
        logic [15:0] ilt;
        logic mc;
        logic bc;
        logic [7:0] rod;
        logic rov;
        logic rol;
        logic roe;
        logic [5:0] stat;
        logic [15:0] nfr;
        logic [15:0] nbad;
    } efme_state_t;

    efme_state_t s;
    efme_state_t n;
    logic rs1_r;
    logic rst_q_n;
    logic req;
    logic go;
    logic [4:0] gtot;
    logic [4:0] surplus;
    logic [31:0] tcrc_nxt;
    logic vlan;
    logic [15:0] eff;
    logic is_len;
    logic [15:0] hdr;
    logic trim;
    logic pass;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion is immediate
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r <= 1'b0;
            rst_q_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_q_n <= rs1_r;
        end
    end

    // Frame decode of the received header, shared by trim and check; also bus request, gap start test and transmit CRC step
    always_comb begin
        vlan = s.lt == efme_pkg::LT_VLAN;
        eff = vlan ? s.ilt : s.lt;
        is_len = eff < efme_pkg::TYPE_MIN;
        hdr = vlan ? efme_pkg::VLAN_HDR : efme_pkg::HDR_LEN;
        pass = s.cfg[efme_pkg::CFG_RX_PASS];
        trim = !pass && is_len && (eff < efme_pkg::MIN_DATA);
        req = avs_read || avs_write;
        gtot = {1'b0, s.gap} + (s.cfg[efme_pkg::CFG_DIC] ? {3'h0, s.dic} : 5'h00);
        surplus = gtot - {1'b0, efme_pkg::IFG_BYTES};
        // Start only at lane 0 once the gap, plus any credit, covers twelve bytes
        go = tx_in_valid && (s.lane == 2'h0) && (gtot >= {1'b0, efme_pkg::IFG_BYTES});
        tcrc_nxt = efme_pkg::efme_crc_byte(s.tcrc, (s.tx_st == efme_pkg::TX_PAD) ?
            efme_pkg::PAD_BYTE : tx_in_data);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state of bus, transmit and receive
    always_comb begin
        logic bad;
        logic lerr;
        logic cand_v;
        logic [7:0] cand;
        logic [15:0] dlen;
        bad = 1'b0;
        lerr = 1'b0;
        cand_v = 1'b0;
        cand = 8'h00;
        dlen = 16'h0000;
        n = s;

        // Bus: one wait cycle, write and read data at the released edge
        n.ack = req && !s.ack;
        if (req && !s.ack) begin
            if (avs_address == efme_pkg::REG_CONFIG) begin
                n.rdata = {28'h0000000, s.cfg};
            end else if (avs_address == efme_pkg::REG_STATUS) begin
                n.rdata = {25'h0000000, s.tx_st != efme_pkg::TX_GAP, s.stat};
            end else if (avs_address == efme_pkg::REG_RX_FRAMES) begin
                n.rdata = {16'h0000, s.nfr};
            end else if (avs_address == efme_pkg::REG_RX_BAD) begin
                n.rdata = {16'h0000, s.nbad};
            end else begin
                n.rdata = 32'h00000000;
            end
        end
        if (avs_write && s.ack && avs_byteenable[0] && avs_address == efme_pkg::REG_CONFIG) begin
            n.cfg = avs_writedata[3:0];
        end

        // Transmit framer, one byte per clock
        n.lane = s.lane + 2'h1;
        n.txc = 1'b0;
        case (s.tx_st)
            efme_pkg::TX_GAP: begin
                n.txd = efme_pkg::IDLE_CODE;
                n.txc = 1'b1;
                if (s.gap != efme_pkg::GAP_SAT) n.gap = s.gap + 4'h1;
                if (go) begin
                    n.txd = efme_pkg::PRE_BYTE;
                    n.txc = 1'b0;
                    n.tx_st = efme_pkg::TX_PRE;
                    n.pcnt = 3'h1;
                    // Leftover idles become credit, capped at three
                    n.dic = !s.cfg[efme_pkg::CFG_DIC] ? 2'h0 : (surplus > 5'h03) ?
                        efme_pkg::DIC_MAX : surplus[1:0];
                end
            end
            efme_pkg::TX_PRE: begin
                n.txd = efme_pkg::PRE_BYTE;
                n.pcnt = s.pcnt + 3'h1;
                if (s.pcnt == efme_pkg::PRE_LEN - 3'h1) n.tx_st = efme_pkg::TX_SFD;
            end
            efme_pkg::TX_SFD: begin
                n.txd = efme_pkg::SFD_BYTE;
                n.tx_st = efme_pkg::TX_DATA;
                n.tcnt = 16'h0000;
                n.tcrc = efme_pkg::CRC_INIT;
            end
            efme_pkg::TX_DATA: begin
                if (tx_in_valid) begin
                    // Addresses and length/type pass untouched, in order
                    n.txd = tx_in_data;
                    n.tcrc = tcrc_nxt;
                    n.tcnt = s.tcnt + 16'h0001;
                    if (tx_in_last) begin
                        n.fcs = ~tcrc_nxt;
                        n.pcnt = 3'h0;
                        if (s.cfg[efme_pkg::CFG_TX_INBAND]) begin
                            n.tx_st = efme_pkg::TX_TERM;
                        end else if (s.tcnt + 16'h0001 < efme_pkg::MIN_FRAME) begin
                            n.tx_st = efme_pkg::TX_PAD;
                        end else begin
                            n.tx_st = efme_pkg::TX_FCS;
                        end
                    end
                end else begin
                    // Underrun: poison the frame rather than send a short one
                    n.txd = efme_pkg::ERR_CODE;
                    n.txc = 1'b1;
                    n.tx_st = efme_pkg::TX_TERM;
                end
            end
            efme_pkg::TX_PAD: begin
                n.txd = efme_pkg::PAD_BYTE;
                n.tcrc = tcrc_nxt;
                n.tcnt = s.tcnt + 16'h0001;
                n.fcs = ~tcrc_nxt;
                if (s.tcnt + 16'h0001 >= efme_pkg::MIN_FRAME) n.tx_st = efme_pkg::TX_FCS;
            end
            efme_pkg::TX_FCS: begin
                // Low byte of reflected CRC first puts the x31 term on the wire first
                n.txd = s.fcs[7:0];
                n.fcs = {8'h00, s.fcs[31:8]};
                n.pcnt = s.pcnt + 3'h1;
                if (s.pcnt == efme_pkg::FCS_LAST) n.tx_st = efme_pkg::TX_TERM;
            end
            default: begin
                n.txd = efme_pkg::TERM_CODE;
                n.txc = 1'b1;
                n.gap = 4'h1;
                n.tx_st = efme_pkg::TX_GAP;
            end
        endcase

        // Receive deframer
        n.rov = 1'b0;
        n.rol = 1'b0;
        n.roe = 1'b0;
        case (s.rx_st)
            efme_pkg::RX_IDLE: begin
                if (!pcs_rxc && pcs_rxd == efme_pkg::PRE_BYTE) n.rx_st = efme_pkg::RX_PRE;
            end
            efme_pkg::RX_PRE: begin
                if (pcs_rxc || (pcs_rxd != efme_pkg::PRE_BYTE && pcs_rxd != efme_pkg::SFD_BYTE)) begin
                    n.rx_st = efme_pkg::RX_IDLE;
                end else if (pcs_rxd == efme_pkg::SFD_BYTE) begin
                    // Preamble and delimiter never reach the client
                    n.rx_st = efme_pkg::RX_DATA;
                    n.rcnt = 16'h0000;
                    n.oidx = 16'h0000;
                    n.rcrc = efme_pkg::CRC_INIT;
                    n.pv = 1'b0;
                    n.lt = 16'h0000;
                    n.ilt = 16'h0000;
                    n.mc = 1'b0;
                    n.bc = 1'b1;
                end
            end
            default: begin
                if (pcs_rxc) begin
                    // Residue check covers the FCS itself
                    bad = (s.rcrc != efme_pkg::CRC_RESIDUE) || (pcs_rxd != efme_pkg::TERM_CODE);
                    dlen = s.rcnt - efme_pkg::FCS_LEN - hdr;
                    lerr = s.cfg[efme_pkg::CFG_LEN_CHK] && is_len && ((eff < efme_pkg::MIN_DATA) ?
                        (dlen != efme_pkg::MIN_DATA) : (dlen != eff));
                    n.rod = s.pend;
                    n.rov = s.pv;
                    n.rol = s.pv;
                    n.roe = bad || lerr;
                    n.stat = {s.bc, s.mc, s.lt == efme_pkg::LT_PAUSE, vlan, lerr, bad};
                    n.nfr = s.nfr + 16'h0001;
                    if (bad || lerr) n.nbad = s.nbad + 16'h0001;
                    n.pv = 1'b0;
                    n.rx_st = efme_pkg::RX_IDLE;
                end else begin
                    // No length cap: jumbo data runs until any control byte
                    n.rcrc = efme_pkg::efme_crc_byte(s.rcrc, pcs_rxd);
                    n.rcnt = s.rcnt + 16'h0001;
                    if (s.rcnt == 16'h0000) n.mc = pcs_rxd[0];
                    if (s.rcnt < efme_pkg::ADDR_LEN) n.bc = s.bc && (pcs_rxd == efme_pkg::ONES_BYTE);
                    if (s.rcnt == efme_pkg::LT_POS) n.lt[15:8] = pcs_rxd;
                    if (s.rcnt == efme_pkg::LT_POS + 16'h0001) n.lt[7:0] = pcs_rxd;
                    if (vlan && s.rcnt == efme_pkg::ILT_POS) n.ilt[15:8] = pcs_rxd;
                    if (vlan && s.rcnt == efme_pkg::ILT_POS + 16'h0001) n.ilt[7:0] = pcs_rxd;
                    // Four-byte delay line hides the FCS when it is dropped
                    n.sh = {s.sh[23:0], pcs_rxd};
                    cand_v = pass || (s.rcnt >= efme_pkg::FCS_LEN);
                    cand = pass ? pcs_rxd : s.sh[31:24];
                    if (cand_v) begin
                        n.oidx = s.oidx + 16'h0001;
                        // Type frames and long frames keep every byte
                        if (!(trim && s.oidx >= hdr + eff)) begin
                            n.rod = s.pend;
                            n.rov = s.pv;
                            n.pend = cand;
                            n.pv = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            s <= '0;
            s.cfg <= efme_pkg::CFG_RESET;
            s.gap <= efme_pkg::GAP_SAT;
            s.txd <= efme_pkg::IDLE_CODE;
            s.txc <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs; waitrequest and ready are combinational handshakes
    assign avs_waitrequest = req && !s.ack;
    assign avs_readdata = s.rdata;
    assign tx_in_ready = s.tx_st == efme_pkg::TX_DATA;
    assign pcs_txd = s.txd;
    assign pcs_txc = s.txc;
    assign rx_out_data = s.rod;
    assign rx_out_valid = s.rov;
    assign rx_out_last = s.rol;
    assign rx_out_err = s.roe;

    ////////////////////////////////////////////////////////////////////////////
    // Helper: bytes delivered in the current receive frame
    logic [15:0] ocnt_r;
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) ocnt_r <= 16'h0000;
        else if (rx_out_last) ocnt_r <= 16'h0000;
        else if (rx_out_valid) ocnt_r <= ocnt_r + 16'h0001;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_q_n);

    AST_PRE_SEVEN: assert property ($rose(s.tx_st == efme_pkg::TX_DATA) |->
        $past(pcs_txd, 1) == efme_pkg::PRE_BYTE && $past(pcs_txd, 7) == efme_pkg::PRE_BYTE
        && $past(pcs_txc, 8)) else $error("preamble not seven bytes");
    AST_SFD_NEXT: assert property ($rose(s.tx_st == efme_pkg::TX_DATA) |->
        pcs_txd == efme_pkg::SFD_BYTE && !pcs_txc) else $error("delimiter missing");
    AST_TX_FORWARD: assert property (tx_in_ready && tx_in_valid |=>
        pcs_txd == $past(tx_in_data) && !pcs_txc) else $error("transmit byte altered");
    AST_START_ALIGN: assert property ($rose(s.tx_st == efme_pkg::TX_PRE) |->
        s.lane == 2'h1) else $error("start not on lane 0");
    AST_IFG_MIN: assert property ($rose(s.tx_st == efme_pkg::TX_PRE) &&
        !$past(s.cfg[efme_pkg::CFG_DIC]) |-> $past(s.gap) >= efme_pkg::IFG_BYTES)
        else $error("gap below twelve bytes");
    AST_DIC_CREDIT: assert property ($rose(s.tx_st == efme_pkg::TX_PRE) |->
        {1'b0, $past(s.gap)} + {3'h0, $past(s.dic)} >= {1'b0, efme_pkg::IFG_BYTES})
        else $error("gap shortened beyond credit");
    AST_MIN_FRAME: assert property ($rose(s.tx_st == efme_pkg::TX_FCS) |->
        s.tcnt >= efme_pkg::MIN_FRAME) else $error("short frame before FCS");
    AST_FCS_FOUR: assert property ($rose(s.tx_st == efme_pkg::TX_FCS) |->
        (s.tx_st == efme_pkg::TX_FCS)[*4] ##1 s.tx_st == efme_pkg::TX_TERM)
        else $error("FCS not four bytes");
    AST_RX_STRIP: assert property ($rose(s.rx_st == efme_pkg::RX_DATA) |->
        !rx_out_valid [*2]) else $error("preamble reached client");
    AST_RX_TRIM: assert property (rx_out_valid && trim |->
        ocnt_r < hdr + eff) else $error("pad byte delivered");
    AST_RX_FCS: assert property (rx_out_last |-> rx_out_err == (s.stat[0] || s.stat[1])
        && s.stat[0] == ($past(s.rcrc) != efme_pkg::CRC_RESIDUE
        || $past(pcs_rxd) != efme_pkg::TERM_CODE)) else $error("bad frame not reported");

    COV_TX_PAD: cover property ($rose(s.tx_st == efme_pkg::TX_PAD));
    COV_DIC_SHORT: cover property ($rose(s.tx_st == efme_pkg::TX_PRE) &&
        $past(s.gap) < efme_pkg::IFG_BYTES);
    COV_RX_GOOD: cover property (rx_out_last && !rx_out_err);
    COV_RX_VLAN: cover property (rx_out_last && s.stat[2]);
endmodule

// ==== tb/efme_pcs_loop.sv ====
// PCS stand-in: hands every transmit byte back to the receiver one cycle later.
// Assumes the engine's clock; damages a data byte only while the bench asks.
module efme_pcs_loop (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Engine transmit side
    input wire logic [7:0] txd,
    input wire logic txc,
    // Engine receive side
    output logic [7:0] rxd,
    output logic rxc,
    // Damage request
    input wire logic corrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // Loopback register; idles in reset so no stray frame start is seen
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxd <= efme_pkg::IDLE_CODE;
            rxc <= 1'b1;
        end else begin
            rxd <= (corrupt && !txc) ? (txd ^ 8'h01) : txd; // Bit flip spoils check value
            rxc <= txc;
        end
    end
endmodule

// ==== tb/test_ethernet_frame_mac_engine.sv ====
// Bench for the framing engine: transmit frames loop back into the receiver.
// Assumes efme_top on one 40 MHz clock and the loopback PCS stand-in.
module test_ethernet_frame_mac_engine;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] tx_in_data = 8'h00;
    logic tx_in_valid = 1'b0;
    logic tx_in_last = 1'b0;
    logic tx_in_ready;
    logic [7:0] pcs_txd;
    logic pcs_txc;
    logic [7:0] pcs_rxd;
    logic pcs_rxc;
    logic [7:0] rx_out_data;
    logic rx_out_valid;
    logic rx_out_last;
    logic rx_out_err;
    logic corrupt = 1'b0;
    logic last_err;
    logic prev_c = 1'b1;
    logic [31:0] rd;
    int n_fail = 0;
    int checked = 0;
    int n_last = 0;
    int cyc = 0;
    int t_term = 0;
    int t_start = 0;
    int gap = 0;
    int span = 0;
    logic [7:0] fr[$];
    logic [7:0] ex[$];
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    ////////////////////////////////////////////////////////////////////////////
    // Clock; byte lanes all enabled since only lane 0 is used
    always #12.5 clk_sys = ~clk_sys;
    efme_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_in_data(tx_in_data), .tx_in_valid(tx_in_valid), .tx_in_last(tx_in_last),
        .tx_in_ready(tx_in_ready), .pcs_txd(pcs_txd), .pcs_txc(pcs_txc), .pcs_rxd(pcs_rxd),
        .pcs_rxc(pcs_rxc), .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid),
        .rx_out_last(rx_out_last), .rx_out_err(rx_out_err));
    efme_pcs_loop i_pcs (.clk_sys(clk_sys), .rst_n(rst_n), .txd(pcs_txd), .txc(pcs_txc),
        .rxd(pcs_rxd), .rxc(pcs_rxc), .corrupt(corrupt));
    ////////////////////////////////////////////////////////////////////////////
    // Line and client monitor; start spacing shows lane alignment
    always @(posedge clk_sys) begin
        cyc++;
        if (pcs_txc === 1'b0) txq.push_back(pcs_txd);
        if (pcs_txc === 1'b0 && prev_c === 1'b1) begin
            gap = cyc - t_term;
            span = cyc - t_start;
            t_start = cyc;
        end
        if (pcs_txc === 1'b1 && pcs_txd === efme_pkg::TERM_CODE) t_term = cyc;
        prev_c = pcs_txc;
        if (rx_out_valid === 1'b1) rxq.push_back(rx_out_data);
        if (rx_out_last === 1'b1) begin
            n_last++;
            last_err = rx_out_err;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and hang handling
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task hang(input string nm);
        n_fail++;
        $display("BAD %s expected done seen timeout", nm);
        tally_and_finish;
    endtask
    // Register access; a spare edge after release keeps requests apart
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            w++;
        end while (avs_waitrequest !== 1'b0 && w < 50);
        if (w >= 50) hang("waitrequest");
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Frame: destination, source, length/type, counting data
    task build(input logic [7:0] d0, input logic [15:0] lt, input int nd);
        fr = {};
        for (int k = 0; k < 6; k++) fr.push_back((k == 0 || d0 == 8'hFF) ? d0 : 8'h00);
        for (int k = 0; k < 6; k++) fr.push_back(8'(8'h10 + k));
        fr.push_back(lt[15:8]);
        fr.push_back(lt[7:0]);
        for (int k = 0; k < nd; k++) fr.push_back(8'(k + 1));
    endtask
    // Expected line contents after the delimiter: padded frame plus check value
    task make_exp;
        logic [31:0] c;
        ex = fr;
        while (ex.size() < 60) ex.push_back(8'h00);
        c = 32'hFFFFFFFF;
        foreach (ex[k]) for (int b = 0; b < 8; b++)
            c = (c[0] ^ ex[k][b]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
        c = ~c;
        for (int k = 0; k < 4; k++) ex.push_back(c[8*k +: 8]);
    endtask
    // Hands one frame over; ready is looked at mid-cycle to avoid edge races
    task send(input int n, input logic dmg);
        int i;
        int w;
        logic tk;
        i = 0;
        w = 0;
        tx_in_valid <= 1'b1;
        tx_in_data <= fr[0];
        tx_in_last <= (n == 1);
        while (i < n && w < 4000) begin
            @(negedge clk_sys);
            w++;
            tk = (tx_in_ready === 1'b1);
            @(posedge clk_sys);
            corrupt <= dmg && (i == 10);
            if (tk) i++;
            if (tk && i < n) begin
                tx_in_data <= fr[i];
                tx_in_last <= (i == n - 1);
            end
        end
        if (i < n) hang("transmit ready");
        tx_in_valid <= 1'b0;
        tx_in_last <= 1'b0;
        @(posedge clk_sys);
    endtask
    task wait_last(input int k);
        int w;
        w = 0;
        while (n_last < k && w < 3000) begin
            @(negedge clk_sys);
            w++;
        end
        if (n_last < k) hang("frame end");
        repeat (4) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task scen_regs;
        bus(1'b0, efme_pkg::REG_CONFIG, 32'h0);
        chk("config reset", 32'(efme_pkg::CFG_RESET), rd);
        bus(1'b1, efme_pkg::REG_CONFIG, 32'h5);
        bus(1'b0, efme_pkg::REG_CONFIG, 32'h0);
        chk("config", 32'h5, rd);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, efme_pkg::REG_CONFIG, 32'h0);
    endtask
    task scen_short;
        int k;
        k = n_last;
        txq = {};
        rxq = {};
        build(8'hFF, 16'h0002, 2);
        make_exp;
        send(fr.size(), 1'b0);
        wait_last(k + 1);
        for (int i = 0; i < 7; i++) chk("preamble", 32'h55, txq[i]);
        chk("delimiter", 32'hD5, txq[7]);
        foreach (ex[i]) chk("line byte", ex[i], txq[8 + i]);
        chk("line length", 32'd72, txq.size());
        foreach (fr[i]) chk("rx byte", fr[i], rxq[i]);
        chk("rx length", 32'd16, rxq.size());
        chk("rx err", 32'h0, last_err);
        bus(1'b0, efme_pkg::REG_STATUS, 32'h0);
        chk("broadcast", 32'h1, rd[5]);
    endtask
    task scen_pause_pair;
        int k;
        k = n_last;
        rxq = {};
        bus(1'b1, efme_pkg::REG_CONFIG, 32'hA);
        build(8'h01, efme_pkg::LT_PAUSE, 47);
        make_exp;
        send(fr.size(), 1'b0);
        send(fr.size(), 1'b0);
        wait_last(k + 2);
        foreach (ex[i]) chk("rx pass byte", ex[i], rxq[i]);
        foreach (ex[i]) chk("rx second byte", ex[i], rxq[ex.size() + i]);
        // 65-byte frames end off lane; credit of three pulls the start in to eleven
        chk("gap", 32'd11, gap);
        chk("start lane", 32'h0, span % 4);
        bus(1'b0, efme_pkg::REG_STATUS, 32'h0);
        chk("status kind", 32'h3, rd[5:3]);
    endtask
    task scen_errors;
        int k;
        logic [31:0] bad0;
        bus(1'b1, efme_pkg::REG_CONFIG, 32'h4);
        bus(1'b0, efme_pkg::REG_RX_BAD, 32'h0);
        bad0 = rd;
        k = n_last;
        build(8'h02, efme_pkg::LT_VLAN, 50);
        send(fr.size(), 1'b0);
        wait_last(k + 1);
        chk("length err", 32'h1, last_err);
        bus(1'b0, efme_pkg::REG_STATUS, 32'h0);
        chk("vlan", 32'h1, rd[2]);
        build(8'h02, 16'h0002, 2);
        send(fr.size(), 1'b1);
        wait_last(k + 2);
        chk("fcs err", 32'h1, last_err);
        bus(1'b0, efme_pkg::REG_RX_BAD, 32'h0);
        chk("bad count", bad0 + 32'h2, rd);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        scen_regs;
        scen_short;
        scen_pause_pair;
        scen_errors;
        tally_and_finish;
    end
endmodule
